// file: common/dcu_defines.svh
// constants for the converter input update control block
// assumes inclusion by bare name from design and bench files
`ifndef DCU_DEFINES_SVH
`define DCU_DEFINES_SVH

// ****************************************
// register byte addresses
// ****************************************
`define DCU_OFF_CONTROL    8'h00
`define DCU_OFF_VALUE_LOW  8'h04
`define DCU_OFF_VALUE_HIGH 8'h08
`define DCU_OFF_STATUS     8'h0c

// ****************************************
// control field positions
// ****************************************
`define DCU_BIT_ENABLE     0
`define DCU_BIT_LEFT       2
`define DCU_BIT_TSEL_LO    4
`define DCU_BIT_TSEL_HI    6
`define DCU_BIT_AUTO       7
`define DCU_CONTROL_MASK   8'hf5

// ****************************************
// reset values and timing
// ****************************************
`define DCU_RST_BYTE       8'h00
`define DCU_CLK_MHZ        25
`define DCU_CONV_NS        200
`define DCU_CONV_CYCLES    ((`DCU_CONV_NS * `DCU_CLK_MHZ + 999) / 1000)

`endif

// file: common/dcu_pkg.sv
// types for the converter input update control block
// assumes dcu_defines.svh is on the include path
package dcu_pkg;
   // trigger source codes
   typedef enum logic [2:0] {
      DCU_TS_CMP0  = 3'b000,
      DCU_TS_CMP1  = 3'b001,
      DCU_TS_EXT0  = 3'b010,
      DCU_TS_RES3  = 3'b011,
      DCU_TS_RES4  = 3'b100,
      DCU_TS_RES5  = 3'b101,
      DCU_TS_T1OVF = 3'b110,
      DCU_TS_T1CAP = 3'b111
   } dcu_tsel_t;

   // on-chip interrupt flag levels
   typedef struct packed {
      logic cmp0;
      logic cmp1;
      logic ext0;
      logic t1_ovf;
      logic t1_cap;
   } dcu_flags_t;

   // value driven to the analog core
   typedef struct packed {
      logic       enable;
      logic [9:0] value;
   } dcu_core_t;

   // conversion sequencer
   typedef enum logic [0:0] {
      DCU_IDLE = 1'b0,
      DCU_BUSY = 1'b1
   } dcu_state_t;
endpackage

// file: verilog/dcu_trigger.sv
// trigger selection and rising edge detection
// assumes flag inputs already on aclk
`timescale 1ns/1ps
`include "dcu_defines.svh"
module dcu_trigger (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // selection
   input  wire logic              auto_trigger_enable,
   input  wire dcu_pkg::dcu_tsel_t trigger_select,
   input  wire dcu_pkg::dcu_flags_t flags,
   // event
   output logic                   trigger_edge
);
   import dcu_pkg::*;

   logic sel_level;
   logic sel_prev;

   // pick the selected flag; reserved codes give no trigger
   always_comb begin
      unique case (trigger_select)
         DCU_TS_CMP0:  sel_level = flags.cmp0;
         DCU_TS_CMP1:  sel_level = flags.cmp1;
         DCU_TS_EXT0:  sel_level = flags.ext0;
         DCU_TS_T1OVF: sel_level = flags.t1_ovf;
         DCU_TS_T1CAP: sel_level = flags.t1_cap;
         DCU_TS_RES3,
         DCU_TS_RES4,
         DCU_TS_RES5:  sel_level = 1'b0;
      endcase
   end

   // previous level of the selected flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_prev <= 1'b0;
      end else begin
         sel_prev <= sel_level;
      end
   end

   // edge only counts in auto mode; flag level alone fires only on a select change from a low flag to a high one
   assign trigger_edge = auto_trigger_enable & sel_level & ~sel_prev;
endmodule

// file: verilog/dcu_core.sv
// converter input update control with axi4-lite register slave
// assumes flags come from aclk logic on chip; analog core outside
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "dcu_defines.svh"
module dcu_core (
   // clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // axi4-lite write address
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   // axi4-lite write response
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   // axi4-lite read data
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // interrupt flag sources
   input  wire dcu_pkg::dcu_flags_t flags,
   // analog core
   output dcu_pkg::dcu_core_t       core
);
   import dcu_pkg::*;

   // ****************************************
   // storage
   // ****************************************
   logic [7:0]  converter_control;
   logic [7:0]  converter_value_low;
   logic [7:0]  converter_value_high;
   logic [9:0]  shadow;
   logic        low_pending;
   logic        high_seen;
   dcu_state_t  state;
   logic [3:0]  conv_cnt;
   logic [7:0]  aw_addr;
   logic        aw_held;
   logic [31:0] w_data;
   logic        w_held;
   logic        w_lane0;
   logic [7:0]  next_rdata;
   logic        trigger_edge;
   logic        wr_fire;
   logic        wr_low;
   logic        wr_high;
   logic        wr_ctrl;
   logic        do_update;
   logic [9:0]  assembled;

   localparam logic [3:0] CONV_LAST = 4'(`DCU_CONV_CYCLES - 1);

   // map register address to a known slot
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == `DCU_OFF_CONTROL) || (a == `DCU_OFF_VALUE_LOW) ||
                (a == `DCU_OFF_VALUE_HIGH) || (a == `DCU_OFF_STATUS);
   endfunction

   // ****************************************
   // axi4-lite write path
   // ****************************************
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;

   // hold address and data until both are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_lane0 <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0]; // strobe belongs to the data beat
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // response, slverr on unmapped address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_ok(aw_addr) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // byte lane 0, captured with the data, carries every register
   assign wr_ctrl = wr_fire & (aw_addr == `DCU_OFF_CONTROL) & w_lane0;
   assign wr_low  = wr_fire & (aw_addr == `DCU_OFF_VALUE_LOW) & w_lane0;
   assign wr_high = wr_fire & (aw_addr == `DCU_OFF_VALUE_HIGH) & w_lane0;

   // control register, reserved bits masked
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         converter_control <= `DCU_RST_BYTE;
      end else if (wr_ctrl) begin
         converter_control <= w_data[7:0] & `DCU_CONTROL_MASK;
      end
   end

   // data byte registers; unused bits follow the layout in force
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         converter_value_low  <= `DCU_RST_BYTE;
         converter_value_high <= `DCU_RST_BYTE;
      end else begin
         if (wr_low) begin
            converter_value_low <= converter_control[`DCU_BIT_LEFT] ?
                                   {w_data[7:6], 6'h00} : w_data[7:0];
         end
         if (wr_high) begin
            converter_value_high <= converter_control[`DCU_BIT_LEFT] ?
                                    w_data[7:0] : {6'h00, w_data[1:0]};
         end
      end
   end

   // ****************************************
   // axi4-lite read path
   // ****************************************
   assign s_axi_arready = ~s_axi_rvalid;

   // read mux; shadow never visible
   always_comb begin
      unique case (s_axi_araddr)
         `DCU_OFF_CONTROL:    next_rdata = converter_control;
         `DCU_OFF_VALUE_LOW:  next_rdata = converter_value_low;
         `DCU_OFF_VALUE_HIGH: next_rdata = converter_value_high;
         `DCU_OFF_STATUS:     next_rdata = {6'h00, low_pending, state == DCU_BUSY};
         default:             next_rdata = 8'h00;
      endcase
   end

   // read answer one cycle after address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, next_rdata};
         s_axi_rresp  <= addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // trigger and conversion
   // ****************************************
   dcu_trigger u_trigger (
      .aclk                (aclk),
      .aresetn             (aresetn),
      .auto_trigger_enable (converter_control[`DCU_BIT_AUTO]),
      .trigger_select      (dcu_tsel_t'(converter_control[`DCU_BIT_TSEL_HI:`DCU_BIT_TSEL_LO])),
      .flags               (flags),
      .trigger_edge        (trigger_edge)
   );

   // conversion window; edges inside it are dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state    <= DCU_IDLE;
         conv_cnt <= 4'h0;
      end else begin
         unique case (state)
            DCU_IDLE: begin
               if (do_update) begin
                  state    <= DCU_BUSY;
                  conv_cnt <= 4'h0;
               end
            end
            DCU_BUSY: begin
               if (conv_cnt == CONV_LAST) begin
                  state <= DCU_IDLE;
               end else begin
                  conv_cnt <= conv_cnt + 4'h1;
               end
            end
         endcase
      end
   end

   // pairing guard: low write arms, high write completes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_pending <= 1'b0;
         high_seen   <= 1'b0;
      end else begin
         if (wr_high) begin
            low_pending <= 1'b0;
            high_seen   <= 1'b1;
         end else if (wr_low) begin
            low_pending <= 1'b1;
            high_seen   <= 1'b0;
         end
      end
   end

   // update source depends on mode
   assign do_update = converter_control[`DCU_BIT_AUTO] ?
                      (trigger_edge & (state == DCU_IDLE) & high_seen & ~low_pending) :
                      wr_high;

   // bytes assembled per present layout; high byte taken from the bus on its write
   always_comb begin
      logic [7:0] hi;
      hi = wr_high ? w_data[7:0] : converter_value_high;
      if (converter_control[`DCU_BIT_LEFT]) begin
         assembled = {hi, converter_value_low[7:6]};
      end else begin
         assembled = {hi[1:0], converter_value_low};
      end
   end

   // hidden shadow value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shadow <= 10'h000;
      end else if (do_update) begin
         shadow <= assembled;
      end
   end

   // analog core drive
   assign core.enable = converter_control[`DCU_BIT_ENABLE];
   assign core.value  = shadow;

   // ****************************************
   // checks
   // ****************************************
   chk_shadow_normal: assert property (@(posedge aclk) disable iff (!aresetn)
      (!converter_control[`DCU_BIT_AUTO] && wr_high) |=> shadow == $past(assembled))
      else $error("shadow not loaded on high write");
   chk_low_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
      low_pending && !wr_high |=> $stable(shadow))
      else $error("shadow moved while low byte pending");
   chk_busy_len: assert property (@(posedge aclk) disable iff (!aresetn)
      (state == DCU_IDLE) ##1 (state == DCU_BUSY) |-> (state == DCU_BUSY) [*5] ##1 (state == DCU_IDLE))
      else $error("conversion window length wrong");
   chk_busy_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (state == DCU_BUSY) && converter_control[`DCU_BIT_AUTO] |=> $stable(shadow))
      else $error("shadow moved during conversion");
   chk_auto_no_write: assert property (@(posedge aclk) disable iff (!aresetn)
      converter_control[`DCU_BIT_AUTO] && !trigger_edge |=> $stable(shadow))
      else $error("auto mode updated without trigger");
   chk_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (converter_control & ~`DCU_CONTROL_MASK) == 8'h00)
      else $error("reserved control bit set");
   chk_enable_out: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ctrl |=> core.enable == $past(w_data[0]))
      else $error("enable output not following control");
   chk_no_auto_trig: assert property (@(posedge aclk) disable iff (!aresetn)
      !converter_control[`DCU_BIT_AUTO] |-> !trigger_edge)
      else $error("trigger seen with auto off");
   cov_normal_update: cover property (@(posedge aclk) disable iff (!aresetn)
      wr_low ##[1:20] wr_high);
   cov_auto_update: cover property (@(posedge aclk) disable iff (!aresetn)
      converter_control[`DCU_BIT_AUTO] && do_update);
   cov_edge_dropped: cover property (@(posedge aclk) disable iff (!aresetn)
      trigger_edge && state == DCU_BUSY);
endmodule

// file: test/dcu_flag_model.sv
// interrupt flag sources beside the converter input update control block
// assumes set and clear requests arrive from the bench on aclk
`timescale 1ns/1ps
module dcu_flag_model (
   // clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // requests from the bench
   input  wire logic [4:0]    set_req,
   input  wire logic [4:0]    clr_req,
   // flag levels to the block
   output dcu_pkg::dcu_flags_t flags
);
   import dcu_pkg::*;

   // ****************************************
   // flag levels
   // ****************************************
   // a flag rises on its event, whatever the interrupt enables, and
   // stays set until software clears it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= '0;
      end else begin
         flags <= dcu_flags_t'((flags | set_req) & ~clr_req);
      end
   end
endmodule

// file: test/tb.sv
// self-checking bench for the converter input update control block
// assumes dcu_pkg, dcu_trigger, dcu_core and dcu_flag_model compiled first
`timescale 1ns/1ps
`include "dcu_defines.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb;
   import dcu_pkg::*;

   // ****************************************
   // signals
   // ****************************************
   localparam logic [7:0] a_ctl = `DCU_OFF_CONTROL;
   localparam logic [7:0] a_lo  = `DCU_OFF_VALUE_LOW;
   localparam logic [7:0] a_hi  = `DCU_OFF_VALUE_HIGH;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [4:0]  set_req, clr_req;
   logic [3:0]  wstrb;
   dcu_flags_t  flags;
   dcu_core_t   core;
   logic [9:0]  expv;
   int          error_cnt, n_compared;

   dcu_core i_dcu_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .flags(flags), .core(core));
   dcu_flag_model i_dcu_flag_model (.aclk(aclk), .aresetn(aresetn),
      .set_req(set_req), .clr_req(clr_req), .flags(flags));

   // ****************************************
   // bus and flag tasks
   // ****************************************
   task automatic end_of_test();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic hang(input string what);
      error_cnt++;
      $display("BAD %s exp answer got none", what);
      end_of_test();
   endtask

   // write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st,
                     output logic [1:0] resp);
      int i;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      wstrb   <= st;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      resp = bresp;
      if (i == 50) hang("bvalid");
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      int i;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      d = rdata;
      resp = rresp;
      if (i == 50) hang("rvalid");
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] s;
      wr(a, d, 4'hf, s);
      `CHK("bresp", 2'b00, s)
   endtask

   task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  s;
      rd(a, d, s);
      `CHK("rdata", {24'h0, e}, d)
      `CHK("rresp", 2'b00, s)
   endtask

   task automatic chk_core(input logic e, input logic [9:0] v);
      @(negedge aclk);
      `CHK("enable", e, core.enable)
      `CHK("value", v, core.value)
   endtask

   // one request pulse to the flag model, then time for a shadow load
   task automatic flag_req(input logic [4:0] s, input logic [4:0] c);
      @(posedge aclk);
      set_req <= s;
      clr_req <= c;
      @(posedge aclk);
      set_req <= 5'h00;
      clr_req <= 5'h00;
      repeat (3) @(posedge aclk);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs();
      reg_chk(a_ctl, 8'h00);
      reg_chk(a_hi, 8'h00);
      chk_core(1'b0, 10'h000);
      reg_wr(a_ctl, 8'hff);
      reg_chk(a_ctl, 8'hf5);
      chk_core(1'b1, 10'h000);
      reg_wr(a_ctl, 8'h00);
      chk_core(1'b0, 10'h000);
   endtask

   task automatic t_normal();
      reg_wr(a_ctl, 8'h71);
      reg_wr(a_lo, 8'ha5);
      chk_core(1'b1, 10'h000);
      reg_chk(8'h0c, 8'h02);
      reg_wr(a_hi, 8'hff);
      chk_core(1'b1, 10'h3a5);
      reg_chk(a_hi, 8'h03);
      flag_req(5'h01, 5'h00);
      chk_core(1'b1, 10'h3a5);
      flag_req(5'h00, 5'h1f);
   endtask

   task automatic t_left();
      reg_wr(a_ctl, 8'h05);
      chk_core(1'b1, 10'h3a5);
      reg_wr(a_lo, 8'hff);
      reg_chk(a_lo, 8'hc0);
      reg_wr(a_hi, 8'hab);
      chk_core(1'b1, 10'h2af);
      reg_wr(a_hi, 8'h80);
      chk_core(1'b1, 10'h203);
      reg_wr(a_ctl, 8'h04);
      chk_core(1'b0, 10'h203);
      expv = 10'h203;
   endtask

   task automatic t_auto();
      logic [4:0] fbit [8];
      logic [2:0] c;
      fbit = '{5'h10, 5'h08, 5'h04, 5'h1f, 5'h1f, 5'h1f, 5'h02, 5'h01};
      for (int k = 0; k < 8; k++) begin
         c = k[2:0];
         reg_wr(a_ctl, {1'b1, c, 4'h1});
         reg_wr(a_lo, {5'h08, c});
         reg_wr(a_hi, {6'h00, c[1:0]});
         chk_core(1'b1, expv);
         flag_req(~fbit[k] & 5'h1f, 5'h00);
         chk_core(1'b1, expv);
         flag_req(5'h00, 5'h1f);
         flag_req(fbit[k], 5'h00);
         if (k < 3 || k > 5) expv = {c[1:0], 5'h08, c};
         chk_core(1'b1, expv);
         flag_req(5'h00, 5'h1f);
      end
   endtask

   task automatic t_hold();
      reg_wr(a_ctl, 8'h81);
      reg_wr(a_lo, 8'h11);
      reg_wr(a_hi, 8'h01);
      flag_req(5'h10, 5'h00);
      chk_core(1'b1, 10'h111);
      reg_wr(a_lo, 8'h22);
      reg_wr(a_hi, 8'h02);
      repeat (12) @(posedge aclk);
      chk_core(1'b1, 10'h111);
      flag_req(5'h00, 5'h10);
      reg_wr(a_lo, 8'h33);
      flag_req(5'h10, 5'h00);
      chk_core(1'b1, 10'h111);
      flag_req(5'h00, 5'h10);
      reg_wr(a_hi, 8'h03);
      chk_core(1'b1, 10'h111);
      flag_req(5'h10, 5'h00);
      chk_core(1'b1, 10'h333);
      flag_req(5'h00, 5'h10);
      reg_wr(a_hi, 8'h01);
      flag_req(5'h10, 5'h00);
      chk_core(1'b1, 10'h133);
   endtask

   // second edge inside the conversion window, high byte changed in between
   task automatic t_busy();
      flag_req(5'h00, 5'h10);
      reg_wr(a_hi, 8'h00);
      @(posedge aclk);
      set_req <= 5'h10;
      fork
         reg_wr(a_hi, 8'h02);
         begin
            @(posedge aclk);
            set_req <= 5'h00;
            clr_req <= 5'h10;
            @(posedge aclk);
            set_req <= 5'h10;
            clr_req <= 5'h00;
            @(posedge aclk);
            set_req <= 5'h00;
         end
      join
      repeat (8) @(posedge aclk);
      chk_core(1'b1, 10'h033);
      flag_req(5'h00, 5'h10);
      flag_req(5'h10, 5'h00);
      chk_core(1'b1, 10'h233);
   endtask

   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0]  s;
      wr(8'h10, 8'h55, 4'hf, s);
      `CHK("bresp", 2'b10, s)
      rd(8'h10, d, s);
      `CHK("rresp", 2'b10, s)
      `CHK("rdata", 32'h0, d)
      wr(a_ctl, 8'h00, 4'he, s);
      `CHK("bresp", 2'b00, s)
      reg_chk(a_ctl, 8'h81);
   endtask

   // ****************************************
   // clock, reset and sequence
   // ****************************************
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, set_req, clr_req, wstrb} = '0;
      error_cnt = 0;
      n_compared = 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_normal();
      t_left();
      t_auto();
      t_hold();
      t_busy();
      t_unmapped();
      end_of_test();
   end
endmodule
